// ===== design/clk_src_pkg.sv
// package: codes, fields, reset values and counts for clock source select
package clk_src_pkg;
	localparam logic [3:0] SEL_EXT_CLK = 4'h0;
	localparam logic [3:0] SEL_PLL_RC = 4'h1;
	localparam logic [3:0] SEL_RC8 = 4'h2;
	localparam logic [3:0] SEL_WDOG = 4'h3;
	localparam logic [3:0] SEL_PLL_XTAL = 4'h4;
	localparam logic [3:0] SEL_PLL_EXT = 4'h5;
	localparam logic [3:0] SEL_RC1 = 4'h6;
	localparam logic [3:0] SEL_XTAL_PLL = 4'h7;
	localparam logic [3:0] SEL_XTAL_LO0 = 4'h8;
	localparam logic [3:0] SEL_XTAL_MID4 = 4'hc;
	localparam logic [3:0] SEL_XTAL_MID5 = 4'hd;
	localparam logic [3:0] SEL_XTAL_HI0 = 4'he;
	// factory defaults
	localparam logic [3:0] RST_SEL = 4'h2;
	localparam logic [1:0] RST_SUT = 2'h2;
	localparam logic RST_DIV8 = 1'b0;
	localparam logic [7:0] RST_CAL = 8'h80;
	// register offsets
	localparam logic [3:0] ADDR_SELECT = 4'h0;
	localparam logic [3:0] ADDR_MCU_CTRL = 4'h1;
	localparam logic [3:0] ADDR_CAL = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	// field positions in the selection register, and RC81_BIT in the mcu control register
	localparam int SEL_LSB = 0;
	localparam int SUT_LSB = 4;
	localparam int SWITCH_BIT = 7;
	localparam int RC81_BIT = 0;
	// counts in cycles of the respective source, and PLL_DIV, a divide ratio
	localparam int PD_CK = 6;
	localparam int RST_CK = 14;
	localparam int WD_4MS = 512;
	localparam int WD_64MS = 8192;
	localparam int XTAL_PD_SHORT = 258;
	localparam int XTAL_PD_MID = 1024;
	localparam int XTAL_PD_LONG = 16384;
	localparam int PLL_DIV = 4;

	typedef enum logic [1:0] {
		SRC_RC = 2'h0,
		SRC_EXT = 2'h1,
		SRC_XTAL = 2'h2,
		SRC_WDOG = 2'h3
	} src_t;

	typedef enum logic [1:0] {
		PIN_IO = 2'h0,
		PIN_CLKIN = 2'h1,
		PIN_XTAL = 2'h2
	} pin_role_t;

	typedef struct packed {
		logic [3:0] clock_select_field;
		logic [1:0] startup_time_field;
	} clk_cfg_t;

	typedef struct packed {
		src_t sys_src;
		logic sys_is_pll;
		src_t pll_src;
		logic pll_used;
		logic rc_on;
		pin_role_t pin_first;
		pin_role_t pin_second;
	} clk_route_t;
endpackage : clk_src_pkg

// ===== design/system_clock_source_select.sv
// clock source selection, start-up delay counting and rc trim control
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module system_clock_source_select
	import clk_src_pkg::*;
#(
	parameter int WD_LONG_CYCLES = WD_64MS,
	parameter int WD_SHORT_CYCLES = WD_4MS
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic [3:0] clock_select_fuses_in,
	input wire logic [1:0] startup_time_fuses_in,
	input wire logic divide_by_eight_fuse_in,
	input wire logic reset_pin_disable_fuse_in,
	input wire logic [7:0] factory_cal_in,
	input wire logic wake_in,
	input wire logic sel_clk_tick_in,
	input wire logic wdog_osc_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic [1:0] sys_src_out,
	output logic sys_from_pll_out,
	output logic [1:0] pll_src_out,
	output logic pll_en_out,
	output logic rc_en_out,
	output logic rc_one_mhz_out,
	output logic [7:0] rc_trim_out,
	output logic prescale_eight_out,
	output logic [1:0] pin_first_role_out,
	output logic [1:0] pin_second_role_out,
	output logic core_clk_en_out,
	output logic adc_clk_en_out
);
	typedef enum logic [3:0] {
		ST_RESET = 4'b0001,
		ST_WDOG_WAIT = 4'b0010,
		ST_SRC_WAIT = 4'b0100,
		ST_RUN = 4'b1000
	} phase_t;

	phase_t phase;
	phase_t next_phase;
	clk_cfg_t cfg;
	clk_route_t route;
	logic rc81;
	logic [7:0] cal;
	logic div8;
	logic [14:0] src_cnt;
	logic [14:0] src_target;
	logic [13:0] wd_cnt;
	logic [13:0] wd_target;
	logic [2:0] wd_sync;
	logic wd_level;
	logic wd_edge;
	logic started;
	logic wake_q;
	logic switch_req;

	// fuse inversion: a zero bit is programmed
	function automatic logic fuse_programmed(input logic bit_in);
		fuse_programmed = ~bit_in;
	endfunction : fuse_programmed

	// code decode into sources and pin roles
	function automatic clk_route_t decode(input logic [3:0] code);
		clk_route_t r;
		r = '{SRC_XTAL, 1'b0, SRC_RC, 1'b1, 1'b1, PIN_XTAL, PIN_XTAL};
		case (code)
			SEL_EXT_CLK: r = '{SRC_EXT, 1'b0, SRC_RC, 1'b1, 1'b1,
				PIN_CLKIN, PIN_IO};
			SEL_PLL_RC: r = '{SRC_RC, 1'b1, SRC_RC, 1'b1, 1'b1,
				PIN_IO, PIN_IO};
			SEL_RC8, SEL_RC1: r = '{SRC_RC, 1'b0, SRC_RC, 1'b0, 1'b1,
				PIN_IO, PIN_IO};
			SEL_WDOG: r = '{SRC_WDOG, 1'b0, SRC_RC, 1'b0, 1'b0,
				PIN_IO, PIN_IO};
			SEL_PLL_XTAL: r = '{SRC_XTAL, 1'b1, SRC_XTAL, 1'b1, 1'b0,
				PIN_XTAL, PIN_XTAL};
			SEL_PLL_EXT: r = '{SRC_EXT, 1'b1, SRC_EXT, 1'b1, 1'b0,
				PIN_CLKIN, PIN_IO};
			SEL_XTAL_PLL: r = '{SRC_XTAL, 1'b0, SRC_XTAL, 1'b1, 1'b1,
				PIN_XTAL, PIN_XTAL};
			SEL_XTAL_MID4, SEL_XTAL_MID5: r = '{SRC_XTAL, 1'b0, SRC_RC,
				1'b1, 1'b0, PIN_XTAL, PIN_XTAL};
			default: r = '{SRC_XTAL, 1'b0, SRC_RC, 1'b1, 1'b1,
				PIN_XTAL, PIN_XTAL};
		endcase
		decode = r;
	endfunction : decode

	assign route = decode(cfg.clock_select_field);

	// reset time-out on the watchdog oscillator, whatever the source
	always_comb begin
		case (cfg.startup_time_field)
			2'h1: wd_target = 14'(WD_SHORT_CYCLES);
			2'h2: wd_target = 14'(WD_LONG_CYCLES);
			default: wd_target = fuse_programmed(reset_pin_disable_fuse_in)
				? 14'(WD_SHORT_CYCLES) : 14'h0;
		endcase
		if (route.sys_src == SRC_XTAL && !route.sys_is_pll) begin
			case ({cfg.clock_select_field[0], cfg.startup_time_field})
				3'h0, 3'h3, 3'h6: wd_target = 14'(WD_SHORT_CYCLES);
				3'h1, 3'h4, 3'h7: wd_target = 14'(WD_LONG_CYCLES);
				default: wd_target = 14'h0;
			endcase
		end
	end

	// source cycles: 14 after reset, 6 on wake for rc/ext/wdog
	always_comb begin
		src_target = 15'(PD_CK);
		if (!started)
			src_target = 15'(RST_CK);
		else if (route.sys_src == SRC_XTAL) begin
			case ({cfg.clock_select_field[0], cfg.startup_time_field})
				3'h0, 3'h1: src_target = 15'(XTAL_PD_SHORT);
				3'h2, 3'h3, 3'h4: src_target = 15'(XTAL_PD_MID);
				default: src_target = 15'(XTAL_PD_LONG);
			endcase
		end
	end

	// watchdog oscillator pin: three flops, count when last two agree high
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			wd_sync <= 3'h0;
		else
			wd_sync <= {wd_sync[1:0], wdog_osc_in};
	end

	// agreed level of the last two flops, so a slow high phase counts once
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			wd_level <= 1'b0;
		else if (wd_sync[1] == wd_sync[2])
			wd_level <= wd_sync[2];
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			wd_edge <= 1'b0;
		else
			wd_edge <= wd_sync[1] & wd_sync[2] & ~wd_level;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			wake_q <= 1'b0;
		else
			wake_q <= wake_in;
	end

	assign switch_req = wr_in && addr_in == ADDR_SELECT && wdata_in[SWITCH_BIT];

	// selection register: fuses at reset, software switch later
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			cfg <= '{RST_SEL, RST_SUT};
		else if (phase == ST_RESET)
			cfg <= '{clock_select_fuses_in, startup_time_fuses_in};
		else if (switch_req)
			cfg <= '{wdata_in[SEL_LSB +: 4], wdata_in[SUT_LSB +: 2]};
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			div8 <= RST_DIV8 == 1'b0;
		else if (phase == ST_RESET)
			div8 <= fuse_programmed(divide_by_eight_fuse_in);
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			rc81 <= 1'b0;
		else if (phase == ST_RESET)
			rc81 <= clock_select_fuses_in == SEL_RC1;
		else if (wr_in && addr_in == ADDR_MCU_CTRL)
			rc81 <= wdata_in[RC81_BIT];
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			cal <= RST_CAL;
		else if (phase == ST_RESET)
			cal <= factory_cal_in;
		else if (wr_in && addr_in == ADDR_CAL)
			cal <= wdata_in;
	end

	// start-up sequencer
	always_comb begin
		next_phase = phase;
		case (phase)
			ST_RESET: next_phase = ST_SRC_WAIT;
			ST_SRC_WAIT:
				if (src_cnt >= src_target)
					next_phase = started ? ST_RUN : ST_WDOG_WAIT;
			ST_WDOG_WAIT:
				if (wd_cnt >= wd_target)
					next_phase = ST_RUN;
			ST_RUN:
				if (switch_req || (wake_in && !wake_q))
					next_phase = ST_SRC_WAIT;
			default: next_phase = ST_RESET;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			phase <= ST_RESET;
		else
			phase <= next_phase;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			started <= 1'b0;
		else if (phase == ST_WDOG_WAIT && next_phase == ST_RUN)
			started <= 1'b1;
	end

	// source cycles arrive as ticks of the selected source
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in || phase != ST_SRC_WAIT)
			src_cnt <= 15'h0;
		else if (sel_clk_tick_in)
			src_cnt <= src_cnt + 15'h1;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in || phase != ST_WDOG_WAIT)
			wd_cnt <= 14'h0;
		else if (wd_edge)
			wd_cnt <= wd_cnt + 14'h1;
	end

	// gate opens only from a flop, so no glitch on the enable
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			core_clk_en_out <= 1'b0;
		else
			core_clk_en_out <= next_phase == ST_RUN;
	end

	// converter domain runs regardless of core gating
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			adc_clk_en_out <= 1'b0;
		else
			adc_clk_en_out <= phase != ST_RESET;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			sys_src_out <= SRC_RC;
			sys_from_pll_out <= 1'b0;
		end else begin
			sys_src_out <= route.sys_src;
			sys_from_pll_out <= route.sys_is_pll;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			pll_src_out <= SRC_RC;
			pll_en_out <= 1'b0;
		end else begin
			pll_src_out <= route.pll_src;
			pll_en_out <= route.pll_used;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			rc_en_out <= 1'b1;
		else
			rc_en_out <= route.rc_on;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			pin_first_role_out <= PIN_IO;
			pin_second_role_out <= PIN_IO;
		end else begin
			pin_first_role_out <= route.pin_first;
			pin_second_role_out <= route.pin_second;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			rc_one_mhz_out <= 1'b0;
		else
			rc_one_mhz_out <= rc81;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			rc_trim_out <= RST_CAL;
		else
			rc_trim_out <= cal;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			prescale_eight_out <= 1'b1;
		else
			prescale_eight_out <= div8;
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			rdata_out <= 8'h0;
		else if (rd_in) begin
			case (addr_in)
				ADDR_SELECT: rdata_out <= {2'h0, cfg.startup_time_field,
					cfg.clock_select_field};
				ADDR_MCU_CTRL: rdata_out <= {7'h0, rc81};
				ADDR_CAL: rdata_out <= cal;
				ADDR_STATUS: rdata_out <= {4'h0, phase};
				default: rdata_out <= 8'h0;
			endcase
		end else
			rdata_out <= 8'h0;
	end
endmodule : system_clock_source_select

// ===== verification/osc_partner.sv
// partner model: selected source ticks and free watchdog oscillator
`timescale 1ns/1ps
module osc_partner (
	input wire logic clk_sys_in,
	output logic tick_out,
	output logic wdog_out
);
	logic [7:0] c = 8'h00;
	// one tick per source period, nominal rate
	assign tick_out = c[0];
	// slow phases, eight system cycles each, so the sync never misses one
	assign wdog_out = c[3];
	always @(posedge clk_sys_in) begin
		c <= c + 8'h01;
	end
endmodule : osc_partner

// ===== verification/clk_src_sva.sv
// checker: port relations of the clock source select block
`timescale 1ns/1ps
module clk_src_sva (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic [1:0] sys_src_out,
	input wire logic sys_from_pll_out,
	input wire logic [1:0] pll_src_out,
	input wire logic pll_en_out,
	input wire logic rc_en_out,
	input wire logic [1:0] pin_first_role_out,
	input wire logic [1:0] pin_second_role_out,
	input wire logic core_clk_en_out,
	input wire logic adc_clk_en_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!nrst_in);
	sequence switch_req;
		wr_in && addr_in == 4'h0 && wdata_in[7];
	endsequence
	sequence gated_wait;
		!core_clk_en_out [*4];
	endsequence
	chk_read_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("read data not zero outside read");
	chk_switch_gate: assert property (switch_req |=> gated_wait)
		else $error("core clock not gated after switch");
	chk_reset_gate: assert property (
		$rose(nrst_in) |-> !core_clk_en_out ##1 !core_clk_en_out)
		else $error("core clock on right after reset");
	chk_adc_run: assert property (core_clk_en_out |-> adc_clk_en_out)
		else $error("converter clock off while core runs");
	chk_rc_wdog: assert property (sys_src_out == 2'h3 |-> !rc_en_out)
		else $error("rc on with watchdog source");
	chk_rc_pll: assert property (
		sys_from_pll_out && pll_src_out == 2'h0 |-> rc_en_out)
		else $error("rc off while feeding pll");
	chk_pin_clkin: assert property (
		pin_first_role_out == 2'h1 |-> pin_second_role_out == 2'h0)
		else $error("second pin not io with clock input");
	chk_pin_xtal: assert property (
		pin_first_role_out == 2'h2 |-> pin_second_role_out == 2'h2)
		else $error("crystal pins split");
	chk_pll_on: assert property (sys_from_pll_out |-> pll_en_out)
		else $error("pll off while system runs from it");
endmodule : clk_src_sva

bind system_clock_source_select clk_src_sva chk_u (
	.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .sys_src_out(sys_src_out),
	.sys_from_pll_out(sys_from_pll_out), .pll_src_out(pll_src_out),
	.pll_en_out(pll_en_out), .rc_en_out(rc_en_out),
	.pin_first_role_out(pin_first_role_out),
	.pin_second_role_out(pin_second_role_out),
	.core_clk_en_out(core_clk_en_out), .adc_clk_en_out(adc_clk_en_out)
);

// ===== verification/system_clock_source_select_tb.sv
// testbench: reset, registers, code decode and wake of clock select
`timescale 1ns/1ps
module system_clock_source_select_tb;
	import clk_src_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] fsel = 4'h2;
	logic [1:0] fsut = 2'h2;
	logic div8 = 1'b0;
	logic pdis = 1'b1;
	logic wake = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic tick, wdog, pll, pll_en, rc_en, one_mhz, pre8, core, adc;
	logic [7:0] rdata, trim;
	logic [1:0] sys, psrc, pin1, pin2;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	always #12.5 clk = ~clk;
	osc_partner osc_u (.clk_sys_in(clk), .tick_out(tick), .wdog_out(wdog));
	// short watchdog counts keep the run brief
	system_clock_source_select #(.WD_LONG_CYCLES(8), .WD_SHORT_CYCLES(4))
		dut_u (.clk_sys_in(clk), .nrst_in(nrst), .clock_select_fuses_in(fsel),
		.startup_time_fuses_in(fsut), .divide_by_eight_fuse_in(div8),
		.reset_pin_disable_fuse_in(pdis), .factory_cal_in(8'h5a),
		.wake_in(wake), .sel_clk_tick_in(tick), .wdog_osc_in(wdog),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .sys_src_out(sys), .sys_from_pll_out(pll),
		.pll_src_out(psrc), .pll_en_out(pll_en), .rc_en_out(rc_en),
		.rc_one_mhz_out(one_mhz), .rc_trim_out(trim),
		.prescale_eight_out(pre8), .pin_first_role_out(pin1),
		.pin_second_role_out(pin2), .core_clk_en_out(core),
		.adc_clk_en_out(adc));
	task automatic cmp(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : cmp
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		cmp("read", e, rdata);
	endtask : rd_reg
	// bounded wait, the longest crystal wake needs about 2100 cycles
	task automatic wait_core(input logic v);
		int i;
		i = 0;
		while (core !== v && i < 3000) begin
			@(posedge clk);
			i++;
		end
		#1;
		cmp("core", {7'h0, v}, {7'h0, core});
	endtask : wait_core
	task automatic do_reset(input logic [3:0] s, input logic [1:0] u,
		input logic d, input logic p);
		@(posedge clk);
		nrst <= 1'b0;
		fsel <= s;
		fsut <= u;
		div8 <= d;
		pdis <= p;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		// 14 ticks end near cycle 31; any watchdog wait reaches past 45
		repeat (45) @(posedge clk);
		#1;
		cmp("reset hold", 8'h00, {7'h0, core});
		wait_core(1'b1);
	endtask : do_reset
	task automatic try_code(input logic [3:0] c);
		logic p;
		logic [1:0] s, ps, p1;
		p = (c == 4'h1 || c == 4'h4 || c == 4'h5);
		ps = (c == 4'h4) ? 2'h2 : (c == 4'h5) ? 2'h1 : 2'h0;
		s = (c == 4'h0) ? 2'h1 : (c == 4'h3) ? 2'h3 : (c >= 4'h7) ? 2'h2 : 2'h0;
		p1 = (c == 4'h0 || c == 4'h5) ? 2'h1 :
			(c == 4'h4 || c >= 4'h7) ? 2'h2 : 2'h0;
		wr_reg(4'h0, {4'h8, c});
		repeat (2) @(posedge clk);
		#1;
		cmp("pll", {7'h0, p}, {7'h0, pll});
		if (p) cmp("pll src", {6'h0, ps}, {6'h0, psrc});
		else cmp("sys src", {6'h0, s}, {6'h0, sys});
		cmp("rc en", {7'h0, !(c inside {4'h3, 4'h4, 4'h5, 4'hc, 4'hd})},
			{7'h0, rc_en});
		cmp("pin1", {6'h0, p1}, {6'h0, pin1});
		cmp("pin2", {6'h0, (p1 == 2'h2) ? 2'h2 : 2'h0}, {6'h0, pin2});
		rd_reg(4'h0, {4'h0, c});
		wait_core(1'b1);
	endtask : try_code
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			test_done;
		end
	end
	initial begin
		do_reset(4'h2, 2'h2, 1'b0, 1'b1);
		rd_reg(4'h0, 8'h22);
		rd_reg(4'h1, 8'h00);
		rd_reg(4'h2, 8'h5a);
		rd_reg(4'h3, 8'h08);
		cmp("pre8", 8'h01, {7'h0, pre8});
		wr_reg(4'h2, 8'h33);
		rd_reg(4'h2, 8'h33);
		cmp("trim", 8'h33, trim);
		wr_reg(4'h3, 8'hff);
		rd_reg(4'h3, 8'h08);
		rd_reg(4'hf, 8'h00);
		// no switch bit: the code must not take effect
		wr_reg(4'h0, 8'h03);
		repeat (2) @(posedge clk);
		#1;
		cmp("no switch", 8'h00, {6'h0, sys});
		for (int c = 0; c < 16; c++) try_code(c[3:0]);
		@(posedge clk);
		wake <= 1'b1;
		wait_core(1'b0);
		wait_core(1'b1);
		wake <= 1'b0;
		do_reset(4'h6, 2'h0, 1'b1, 1'b0);
		rd_reg(4'h1, 8'h01);
		cmp("one mhz", 8'h01, {7'h0, one_mhz});
		rd_reg(4'h0, 8'h06);
		rd_reg(4'h2, 8'h5a);
		cmp("pre8", 8'h00, {7'h0, pre8});
		test_done;
	end
endmodule : system_clock_source_select_tb
